// [logic/plt_consts.svh]
`ifndef PLT_CONSTS_SVH
`define PLT_CONSTS_SVH

// command codes
`define PLT_CMD_RATIO 8'h29
`define PLT_CMD_FLOOR 8'h2b
`define PLT_CMD_INPUT_START_THRESHOLD 8'h35
`define PLT_CMD_VIN_OFF 8'h36

// fixed exponent fields
`define PLT_EXP_QUARTER 5'h1e
`define PLT_EXP_FLOOR 5'h17

// feedback ratio mantissas
`define PLT_MANT_ONE 11'h004
`define PLT_MANT_HALF 11'h002
`define PLT_MANT_QTR 11'h001

// output floor limits per ratio, counts of 2^-9 V
`define PLT_FLOOR_RST 12'h0b3
`define PLT_FLOOR_LO1 12'h0b3
`define PLT_FLOOR_HI1 12'h300
`define PLT_FLOOR_LO2 12'h166
`define PLT_FLOOR_HI2 12'h600
`define PLT_FLOOR_LO4 12'h2cc
`define PLT_FLOOR_HI4 12'hc00

// input thresholds in 0.25 V steps
`define PLT_VIN_FIX_HI 7'h01
`define PLT_VIN_FIX_Q 8'h01
`define PLT_VON_MIN 12'h011
`define PLT_VON_MAX 12'h01f
`define PLT_VON_RST 4'h2
`define PLT_VOFF_MIN 12'h010
`define PLT_VOFF_MAX 12'h01e
`define PLT_VOFF_RST 4'h0

// nonvolatile slots
`define PLT_NV_RATIO 2'h0
`define PLT_NV_FLOOR 2'h1
`define PLT_NV_VON 2'h2
`define PLT_NV_VOFF 2'h3
`define PLT_NV_STORE_LAST 3'h3
`define PLT_NV_LOAD_LAST 3'h4

`endif

// [logic/plt_nvm.sv]
`default_nettype none
module plt_nvm #(
	parameter int WIDTH = 16,
	parameter int DEPTH = 4
) (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// write port
	input wire logic we,
	input wire logic [$clog2(DEPTH)-1:0] waddr,
	input wire logic [WIDTH-1:0] wdata,
	// read port
	input wire logic [$clog2(DEPTH)-1:0] raddr,
	output logic [WIDTH-1:0] rdata_r
);
	logic [WIDTH-1:0] mem_r [DEPTH];

	generate
		if (DEPTH < 2 || WIDTH < 1) begin : g_bad_shape
			$error("plt_nvm: unsupported shape");
		end
	endgenerate

	// contents survive reset, as a nonvolatile store should
	always_ff @(posedge mclk) begin
		if (we) begin
			mem_r[waddr] <= wdata;
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			rdata_r <= '0;
		end else begin
			rdata_r <= mem_r[raddr];
		end
	end
endmodule : plt_nvm
`default_nettype wire

// [logic/plt_pkg.sv]
`default_nettype none
package plt_pkg;
	typedef enum logic [1:0] {
		st_idle = 2'b01,
		st_check = 2'b10
	} plt_state_type;
	typedef enum logic [2:0] {
		ratio_qtr = 3'h1,
		ratio_half = 3'h2,
		ratio_one = 3'h4
	} plt_ratio_type;
endpackage : plt_pkg
`default_nettype wire

// [logic/plt_regs.sv]
// What this block does
// - feedback ratio exponent reads fixed 11110; host writes cannot change it
// - ratio mantissa 004h, 002h or 001h; default 004h
// - unsupported ratio write flags cml and invalid data, alerts, keeps ratio
// - output floor bounds the effective target whenever any target source changes
// - floor is unsigned linear, implied exponent -9, about 1.95 mV per count
// - minimum reference is floor times ratio; floor range follows the ratio
// - below floor, on or off: clamp reference to floor, lower upper limit wins
// - clamp while on sets other fault, output voltage and max/min warning, alerts
// - loop slave: ratio and floor access NACKed, invalid command, alert
// - ratio 0.5 floor accepts 358 to 1536, default 358; floor_r is kept on a ratio write, reset value 179
// - ratio 0.25 floor accepts 716 to 3072, default 716; floor_r is kept on a ratio write, reset value 179
// - conversion starts once input reaches start threshold and startup is ok
// - start threshold rounds to 0.25 V steps, 4.25 to 7.75 V, default 4.5
// - out of range start threshold write flags cml, invalid data, keeps value
// - start must exceed stop threshold; violating writes rejected and flagged
// - start word: fixed exponent 11110, only low 4 mantissa bits writable
// - start mantissa 17 to 31, default 18
// - store-all copies the thresholds into nonvolatile memory
`include "plt_consts.svh"
`default_nettype none
module plt_regs (
	// clock and reset
	input wire logic mclk,
	input wire logic srst,
	// command word, complete on cmd_valid
	input wire logic cmd_valid,
	input wire logic cmd_write,
	input wire logic [7:0] cmd_code,
	input wire logic [15:0] cmd_wdata,
	output logic cmd_ready_r,
	// response
	output logic rsp_valid_r,
	output logic rsp_nack_r,
	output logic [15:0] rsp_rdata_r,
	// device controls
	input wire logic loop_slave,
	input wire logic clear_faults,
	input wire logic store_all,
	input wire logic restore_all,
	// output target
	input wire logic output_on,
	input wire logic target_chg,
	input wire logic [11:0] target_req,
	input wire logic [11:0] vmax_ref,
	output logic [11:0] vref_r,
	// input start
	input wire logic [11:0] vin_meas,
	input wire logic startup_ok,
	output logic conv_start_r,
	// status
	output logic cml_r,
	output logic ivd_r,
	output logic ivc_r,
	output logic oth_r,
	output logic vfw_r,
	output logic mmw_r,
	output logic smbalert_n_r
);
	plt_pkg::plt_state_type st_r;
	plt_pkg::plt_state_type st_nxt;
	plt_pkg::plt_ratio_type ratio_r;
	logic [11:0] floor_r;
	logic [3:0] von_r;
	logic [3:0] voff_r;
	logic wr_r;
	logic [7:0] code_r;
	logic [15:0] wdata_r;
	logic [11:0] q_c;
	logic bad_cmd_c;
	logic bad_data_c;
	logic wr_ok_c;
	logic take_cmd;
	logic take_nv;
	logic nv_busy_r;
	logic nv_rest_r;
	logic nv_ok_r;
	logic [2:0] nv_idx_r;
	logic nv_ld_r;
	logic [1:0] nv_ld_idx_r;
	logic nv_end;
	logic nv_busy_nxt;
	logic nv_we;
	logic [15:0] nv_wdata;
	logic [15:0] nv_rdata;
	logic eval_r;
	logic [11:0] floor_ref_c;
	logic [11:0] clamp_c;
	logic below_c;

	function automatic logic [11:0] floor_lo(input plt_pkg::plt_ratio_type r);
		case (r)
			plt_pkg::ratio_half: floor_lo = `PLT_FLOOR_LO2;
			plt_pkg::ratio_qtr: floor_lo = `PLT_FLOOR_LO4;
			default: floor_lo = `PLT_FLOOR_LO1;
		endcase
	endfunction : floor_lo

	function automatic logic [11:0] floor_hi(input plt_pkg::plt_ratio_type r);
		case (r)
			plt_pkg::ratio_half: floor_hi = `PLT_FLOOR_HI2;
			plt_pkg::ratio_qtr: floor_hi = `PLT_FLOOR_HI4;
			default: floor_hi = `PLT_FLOOR_HI1;
		endcase
	endfunction : floor_hi

	// linear word to 0.25 V steps, rounded to nearest; fff means out of reach
	function automatic logic [11:0] to_quarter(input logic [15:0] w);
		logic signed [4:0] e;
		logic [10:0] m;
		int sh;
		int qv;
		e = w[15:11];
		m = w[10:0];
		sh = int'(e) + 2;
		qv = 0;
		if (m[10]) begin
			qv = 4095;
		end else if (sh >= 0) begin
			qv = (sh > 4) ? 4095 : (int'(m) << sh);
		end else begin
			qv = (int'(m) + (1 << (-sh - 1))) >> (-sh);
		end
		to_quarter = (qv > 4095) ? 12'hfff : qv[11:0];
	endfunction : to_quarter

	function automatic logic ratio_ok(input logic [10:0] m);
		ratio_ok = (m == `PLT_MANT_ONE) || (m == `PLT_MANT_HALF) || (m == `PLT_MANT_QTR);
	endfunction : ratio_ok

	// request acceptance
	assign take_cmd = cmd_ready_r & cmd_valid;
	assign take_nv = cmd_ready_r & ~cmd_valid & (store_all | (restore_all & nv_ok_r));
	assign nv_end = nv_busy_r & (nv_idx_r == (nv_rest_r ? `PLT_NV_LOAD_LAST : `PLT_NV_STORE_LAST));
	assign nv_busy_nxt = take_nv | (nv_busy_r & ~nv_end);

	always_comb begin
		case (st_r)
			plt_pkg::st_idle: st_nxt = take_cmd ? plt_pkg::st_check : plt_pkg::st_idle;
			default: st_nxt = plt_pkg::st_idle;
		endcase
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			st_r <= plt_pkg::st_idle;
			cmd_ready_r <= 1'b0;
		end else begin
			st_r <= st_nxt;
			cmd_ready_r <= (st_nxt == plt_pkg::st_idle) & ~nv_busy_nxt;
		end
	end

	// the whole word is latched before any check looks at it
	always_ff @(posedge mclk) begin
		if (srst) begin
			wr_r <= 1'b0;
			code_r <= 8'h00;
			wdata_r <= 16'h0000;
		end else if (take_cmd) begin
			wr_r <= cmd_write;
			code_r <= cmd_code;
			wdata_r <= cmd_wdata;
		end
	end

	// checks on the latched word
	always_comb begin
		bad_cmd_c = 1'b0;
		bad_data_c = 1'b0;
		q_c = to_quarter(wdata_r);
		case (code_r)
			`PLT_CMD_RATIO: begin
				if (loop_slave) begin
					bad_cmd_c = 1'b1;
				end else if (wr_r && !ratio_ok(wdata_r[10:0])) begin
					bad_data_c = 1'b1;
				end
			end
			`PLT_CMD_FLOOR: begin
				if (loop_slave) begin
					bad_cmd_c = 1'b1;
				end else if (wr_r && (wdata_r[11:0] < floor_lo(ratio_r) ||
						wdata_r[11:0] > floor_hi(ratio_r))) begin
					bad_data_c = 1'b1;
				end
			end
			`PLT_CMD_INPUT_START_THRESHOLD: begin
				if (wr_r && (q_c < `PLT_VON_MIN || q_c > `PLT_VON_MAX)) begin
					bad_data_c = 1'b1;
				end else if (wr_r && q_c <= {`PLT_VIN_FIX_Q, voff_r}) begin
					bad_data_c = 1'b1;
				end
			end
			`PLT_CMD_VIN_OFF: begin
				if (wr_r && (q_c < `PLT_VOFF_MIN || q_c > `PLT_VOFF_MAX ||
						q_c >= {`PLT_VIN_FIX_Q, von_r})) begin
					bad_data_c = 1'b1;
				end
			end
			default: bad_cmd_c = 1'b1;
		endcase
	end

	assign wr_ok_c = (st_r == plt_pkg::st_check) & wr_r & ~bad_cmd_c & ~bad_data_c;

	// stored values, each updated in a single edge
	always_ff @(posedge mclk) begin
		if (srst) begin
			ratio_r <= plt_pkg::ratio_one;
			floor_r <= `PLT_FLOOR_RST;
			von_r <= `PLT_VON_RST;
			voff_r <= `PLT_VOFF_RST;
		end else if (nv_ld_r) begin
			case (nv_ld_idx_r)
				`PLT_NV_RATIO: ratio_r <= plt_pkg::plt_ratio_type'(nv_rdata[2:0]);
				`PLT_NV_FLOOR: floor_r <= nv_rdata[11:0];
				`PLT_NV_VON: von_r <= nv_rdata[3:0];
				default: voff_r <= nv_rdata[3:0];
			endcase
		end else if (wr_ok_c) begin
			case (code_r)
				`PLT_CMD_RATIO: ratio_r <= plt_pkg::plt_ratio_type'(wdata_r[2:0]);
				`PLT_CMD_FLOOR: floor_r <= wdata_r[11:0];
				`PLT_CMD_INPUT_START_THRESHOLD: von_r <= q_c[3:0];
				default: voff_r <= q_c[3:0];
			endcase
		end
	end

	// response one edge after the check
	always_ff @(posedge mclk) begin
		if (srst) begin
			rsp_valid_r <= 1'b0;
			rsp_nack_r <= 1'b0;
			rsp_rdata_r <= 16'h0000;
		end else begin
			rsp_valid_r <= (st_r == plt_pkg::st_check);
			rsp_nack_r <= (st_r == plt_pkg::st_check) & bad_cmd_c;
			rsp_rdata_r <= 16'h0000;
			if (st_r == plt_pkg::st_check && !wr_r && !bad_cmd_c) begin
				case (code_r)
					`PLT_CMD_RATIO: rsp_rdata_r <= {`PLT_EXP_QUARTER, 8'h00, ratio_r};
					`PLT_CMD_FLOOR: rsp_rdata_r <= {4'h0, floor_r};
					`PLT_CMD_INPUT_START_THRESHOLD: rsp_rdata_r <= {`PLT_EXP_QUARTER, `PLT_VIN_FIX_HI, von_r};
					default: rsp_rdata_r <= {`PLT_EXP_QUARTER, `PLT_VIN_FIX_HI, voff_r};
				endcase
			end
		end
	end

	// nonvolatile copy and recall sequencer
	always_ff @(posedge mclk) begin
		if (srst) begin
			nv_busy_r <= 1'b0;
			nv_rest_r <= 1'b0;
			nv_idx_r <= 3'h0;
			nv_ld_r <= 1'b0;
			nv_ld_idx_r <= 2'h0;
		end else begin
			nv_ld_r <= nv_busy_r & nv_rest_r & (nv_idx_r != `PLT_NV_LOAD_LAST);
			nv_ld_idx_r <= nv_idx_r[1:0];
			if (take_nv) begin
				nv_busy_r <= 1'b1;
				nv_rest_r <= ~store_all;
				nv_idx_r <= 3'h0;
			end else if (nv_busy_r) begin
				nv_busy_r <= ~nv_end;
				nv_idx_r <= nv_idx_r + 3'h1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			nv_ok_r <= 1'b0;
		end else if (nv_we) begin
			nv_ok_r <= 1'b1;
		end
	end

	assign nv_we = nv_busy_r & ~nv_rest_r;

	always_comb begin
		case (nv_idx_r[1:0])
			`PLT_NV_RATIO: nv_wdata = {`PLT_EXP_QUARTER, 8'h00, ratio_r};
			`PLT_NV_FLOOR: nv_wdata = {4'h0, floor_r};
			`PLT_NV_VON: nv_wdata = {`PLT_EXP_QUARTER, `PLT_VIN_FIX_HI, von_r};
			default: nv_wdata = {`PLT_EXP_QUARTER, `PLT_VIN_FIX_HI, voff_r};
		endcase
	end

	plt_nvm #(.WIDTH(16), .DEPTH(4)) u_nvm (
		.mclk(mclk),
		.srst(srst),
		.we(nv_we),
		.waddr(nv_idx_r[1:0]),
		.wdata(nv_wdata),
		.raddr(nv_idx_r[1:0]),
		.rdata_r(nv_rdata)
	);

	// reference floor in 2^-9 V counts scaled by the ratio
	always_comb begin
		case (ratio_r)
			plt_pkg::ratio_half: floor_ref_c = {1'b0, floor_r[11:1]};
			plt_pkg::ratio_qtr: floor_ref_c = {2'b00, floor_r[11:2]};
			default: floor_ref_c = floor_r;
		endcase
	end

	assign below_c = target_req < floor_ref_c;
	assign clamp_c = (vmax_ref < floor_ref_c) ? vmax_ref : floor_ref_c;

	// re-evaluate when any target source or the floor inputs move
	always_ff @(posedge mclk) begin
		if (srst) begin
			eval_r <= 1'b0;
			vref_r <= `PLT_FLOOR_RST;
		end else begin
			eval_r <= target_chg | (wr_ok_c & (code_r == `PLT_CMD_RATIO ||
				code_r == `PLT_CMD_FLOOR)) | nv_ld_r;
			if (eval_r) begin
				vref_r <= below_c ? clamp_c : target_req;
			end
		end
	end

	// sticky status; a set in the clearing cycle wins
	always_ff @(posedge mclk) begin
		if (srst) begin
			cml_r <= 1'b0;
			ivd_r <= 1'b0;
			ivc_r <= 1'b0;
			oth_r <= 1'b0;
			vfw_r <= 1'b0;
			mmw_r <= 1'b0;
		end else begin
			if (clear_faults) begin
				cml_r <= 1'b0;
				ivd_r <= 1'b0;
				ivc_r <= 1'b0;
				oth_r <= 1'b0;
				vfw_r <= 1'b0;
				mmw_r <= 1'b0;
			end
			if (st_r == plt_pkg::st_check && (bad_cmd_c || bad_data_c)) begin
				cml_r <= 1'b1;
			end
			if (st_r == plt_pkg::st_check && bad_data_c) begin
				ivd_r <= 1'b1;
			end
			if (st_r == plt_pkg::st_check && bad_cmd_c) begin
				ivc_r <= 1'b1;
			end
			if (eval_r && output_on && below_c) begin
				oth_r <= 1'b1;
				vfw_r <= 1'b1;
				mmw_r <= 1'b1;
			end
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			smbalert_n_r <= 1'b1;
		end else begin
			smbalert_n_r <= ~(cml_r | ivd_r | ivc_r | oth_r | vfw_r | mmw_r);
		end
	end

	always_ff @(posedge mclk) begin
		if (srst) begin
			conv_start_r <= 1'b0;
		end else begin
			conv_start_r <= startup_ok & (vin_meas >= {`PLT_VIN_FIX_Q, von_r});
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (srst);

	sequence s_check_wr(logic [7:0] c);
		st_r == plt_pkg::st_check && code_r == c && wr_r;
	endsequence

	property p_ratio_exp;
		rsp_valid_r && !rsp_nack_r && !wr_r && code_r == `PLT_CMD_RATIO
			|-> rsp_rdata_r[15:11] == `PLT_EXP_QUARTER;
	endproperty
	a_ratio_exp: assert property (p_ratio_exp) else $error("ratio exponent wrong");

	property p_ratio_legal;
		ratio_r == plt_pkg::ratio_one || ratio_r == plt_pkg::ratio_half ||
			ratio_r == plt_pkg::ratio_qtr;
	endproperty
	a_ratio_legal: assert property (p_ratio_legal) else $error("ratio illegal");

	property p_ratio_bad;
		s_check_wr(`PLT_CMD_RATIO) and (!loop_slave && !ratio_ok(wdata_r[10:0]))
			|=> $stable(ratio_r) && cml_r && ivd_r ##1 !smbalert_n_r;
	endproperty
	a_ratio_bad: assert property (p_ratio_bad) else $error("bad ratio accepted");

	property p_clamp;
		eval_r && output_on && below_c |=> vref_r == $past(clamp_c) && oth_r && vfw_r && mmw_r;
	endproperty
	a_clamp: assert property (p_clamp) else $error("clamp missing");

	property p_follow;
		eval_r && !below_c |=> vref_r == $past(target_req);
	endproperty
	a_follow: assert property (p_follow) else $error("target not followed");

	property p_slave;
		st_r == plt_pkg::st_check && loop_slave && code_r == `PLT_CMD_FLOOR
			|=> rsp_valid_r && rsp_nack_r && ivc_r && $stable(floor_r);
	endproperty
	a_slave: assert property (p_slave) else $error("slave access not refused");

	property p_floor_oor;
		s_check_wr(`PLT_CMD_FLOOR) and (!loop_slave &&
			wdata_r[11:0] > floor_hi(ratio_r)) |=> $stable(floor_r) && ivd_r;
	endproperty
	a_floor_oor: assert property (p_floor_oor) else $error("floor range missed");

	property p_von_order;
		s_check_wr(`PLT_CMD_INPUT_START_THRESHOLD) and (q_c <= {`PLT_VIN_FIX_Q, voff_r})
			|=> $stable(von_r) && cml_r && ivd_r;
	endproperty
	a_von_order: assert property (p_von_order) else $error("start order missed");

	property p_start;
		conv_start_r |-> $past(startup_ok) && $past(vin_meas) >= {`PLT_VIN_FIX_Q, $past(von_r)};
	endproperty
	a_start: assert property (p_start) else $error("early start");

	sequence s_store;
		nv_we [*4] ##1 !nv_we;
	endsequence

	property p_store;
		take_nv && store_all |=> s_store;
	endproperty
	a_store: assert property (p_store) else $error("store sequence wrong");

	property p_atomic;
		take_cmd |=> st_r == plt_pkg::st_check ##1 rsp_valid_r && cmd_ready_r;
	endproperty
	a_atomic: assert property (p_atomic) else $error("response timing wrong");
endmodule : plt_regs
`default_nettype wire

// [tb/plt_host_model.sv]
`default_nettype none
module plt_host_model (
	// clock
	input wire logic mclk,
	// command port
	input wire logic cmd_ready_r,
	output logic cmd_valid,
	output logic cmd_write,
	output logic [7:0] cmd_code,
	output logic [15:0] cmd_wdata
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		cmd_valid = 1'b0;
		cmd_write = 1'b0;
		cmd_code = 8'h00;
		cmd_wdata = 16'h0000;
	end
	// offers one whole word, holds it until taken, then scrambles the released lines
	task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
		input int idle);
		int n;
		n = 0;
		repeat (idle + 1) @(negedge mclk);
		cmd_write = wr;
		cmd_code = code;
		cmd_wdata = data;
		cmd_valid = 1'b1;
		// ready is read at the falling edge, where it has settled
		while (cmd_ready_r !== 1'b1 && n < 64) begin
			n++;
			@(negedge mclk);
		end
		@(posedge mclk);
		@(negedge mclk);
		cmd_valid = 1'b0;
		cmd_write = ~wr;
		cmd_code = ~code;
		cmd_wdata = ~data;
	endtask : xfer
endmodule : plt_host_model
`default_nettype wire

// [tb/tb_top.sv]
`default_nettype none
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic mclk = 1'b0;
	logic srst, cmd_valid, cmd_write, cmd_ready_r, rsp_valid_r, rsp_nack_r;
	logic [7:0] cmd_code;
	logic [15:0] cmd_wdata, rsp_rdata_r;
	logic loop_slave, clear_faults, store_all, restore_all, output_on, target_chg;
	logic [11:0] target_req, vmax_ref, vref_r, vin_meas, v;
	logic startup_ok, conv_start_r, cml_r, ivd_r, ivc_r, oth_r, vfw_r, mmw_r, smbalert_n_r;
	logic [16:0] exp_q[$];
	logic [16:0] e;
	int mismatches = 0;
	int n_tests = 0;
	int cycles = 0;
	int seed = 62;
	logic [10:0] mant[3] = '{11'h004, 11'h002, 11'h001};
	logic [11:0] lo[3] = '{12'h0b3, 12'h166, 12'h2cc};
	logic [11:0] hi[3] = '{12'h300, 12'h600, 12'hc00};
	always #2 mclk = ~mclk;
	plt_host_model host (.mclk(mclk), .cmd_ready_r(cmd_ready_r), .cmd_valid(cmd_valid),
		.cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata));
	plt_regs dut (.mclk(mclk), .srst(srst), .cmd_valid(cmd_valid), .cmd_write(cmd_write),
		.cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .cmd_ready_r(cmd_ready_r),
		.rsp_valid_r(rsp_valid_r), .rsp_nack_r(rsp_nack_r), .rsp_rdata_r(rsp_rdata_r),
		.loop_slave(loop_slave), .clear_faults(clear_faults), .store_all(store_all),
		.restore_all(restore_all), .output_on(output_on), .target_chg(target_chg),
		.target_req(target_req), .vmax_ref(vmax_ref), .vref_r(vref_r), .vin_meas(vin_meas),
		.startup_ok(startup_ok), .conv_start_r(conv_start_r), .cml_r(cml_r), .ivd_r(ivd_r),
		.ivc_r(ivc_r), .oth_r(oth_r), .vfw_r(vfw_r), .mmw_r(mmw_r),
		.smbalert_n_r(smbalert_n_r));
	task automatic tally_and_finish();
		if (mismatches == 0 && n_tests > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk(input string name, input logic [16:0] exp, input logic [16:0] got);
		n_tests++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h, seen %h", name, exp, got);
		end
	endtask : chk
	task automatic clr();
		@(negedge mclk);
		clear_faults = 1'b1;
		@(negedge mclk);
		clear_faults = 1'b0;
		@(negedge mclk);
	endtask : clr
	// one command; fl is the expected {ivc, ivd, cml}
	task automatic xact(input logic wr, input logic [7:0] code, input logic [15:0] d,
		input logic [16:0] exp, input logic [2:0] fl);
		exp_q.push_back(exp);
		host.xfer(wr, code, d, $unsigned($random(seed)) % 32'h3);
		repeat (3) @(negedge mclk);
		chk("flags", {14'h0, fl}, {14'h0, ivc_r, ivd_r, cml_r});
		chk("alert_n", {16'h0, ~|fl}, {16'h0, smbalert_n_r});
		clr();
	endtask : xact
	task automatic wr(input logic [7:0] code, input logic [15:0] d, input logic [2:0] fl);
		xact(1'b1, code, d, 17'h00000, fl);
	endtask : wr
	task automatic rd(input logic [7:0] code, input logic [15:0] exp);
		xact(1'b0, code, 16'h0000, {1'b0, exp}, 3'b000);
	endtask : rd
	task automatic tgt(input logic on, input logic [11:0] req, input logic [11:0] vmax,
		input logic [11:0] ev, input logic fl);
		@(negedge mclk);
		output_on = on;
		target_req = req;
		vmax_ref = vmax;
		target_chg = 1'b1;
		@(negedge mclk);
		target_chg = 1'b0;
		repeat (2) @(negedge mclk);
		chk("vref", {5'h00, ev}, {5'h00, vref_r});
		chk("clamp_flags", {14'h0, {3{fl}}}, {14'h0, oth_r, vfw_r, mmw_r});
		clr();
	endtask : tgt
	task automatic nv(input logic st);
		int n;
		n = 0;
		@(negedge mclk);
		store_all = st;
		restore_all = ~st;
		@(negedge mclk);
		store_all = 1'b0;
		restore_all = 1'b0;
		while (cmd_ready_r !== 1'b1 && n < 16) begin
			n++;
			@(negedge mclk);
		end
		chk("nv_busy", st ? 17'h00004 : 17'h00005, n[16:0]);
	endtask : nv
	// response watcher
	always @(negedge mclk) begin
		if (rsp_valid_r === 1'b1) begin
			if (exp_q.size() == 0) begin
				mismatches++;
				$display("unexpected response: expected none, seen %h", rsp_rdata_r);
			end else begin
				e = exp_q.pop_front();
				chk("response", e, {rsp_nack_r, rsp_rdata_r});
			end
		end
	end
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 30000) begin
			mismatches++;
			tally_and_finish();
		end
	end
	initial begin
		srst = 1'b1;
		{loop_slave, clear_faults, store_all, restore_all, output_on, target_chg} = 6'h00;
		target_req = 12'h190;
		vmax_ref = 12'h34d;
		vin_meas = 12'h000;
		startup_ok = 1'b0;
		repeat (3) @(negedge mclk);
		srst = 1'b0;
		chk("vref_rst", 17'h000b3, {5'h00, vref_r});
		rd(8'h29, 16'hf004);
		rd(8'h2b, 16'h00b3);
		rd(8'h35, 16'hf012);
		rd(8'h36, 16'hf010);
		for (int i = 0; i < 3; i++) begin
			wr(8'h29, {5'h00, mant[i]}, 3'b000);
			rd(8'h29, {5'h1e, mant[i]});
			wr(8'h2b, {4'h0, lo[i] - 12'h001}, 3'b011);
			wr(8'h2b, {4'h0, hi[i] + 12'h001}, 3'b011);
			wr(8'h2b, {4'h0, lo[i]}, 3'b000);
			wr(8'h2b, {4'h0, hi[i]}, 3'b000);
			rd(8'h2b, {4'h0, hi[i]});
		end
		wr(8'h29, 16'hf003, 3'b011);
		wr(8'h29, 16'hf008, 3'b011);
		rd(8'h29, 16'hf001);
		wr(8'h29, 16'hf002, 3'b000);
		wr(8'h2b, 16'h02cc, 3'b000);
		tgt(1'b1, 12'h12c, 12'h34d, 12'h166, 1'b1);
		tgt(1'b1, 12'h12c, 12'h0c8, 12'h0c8, 1'b1);
		tgt(1'b1, 12'h190, 12'h34d, 12'h190, 1'b0);
		tgt(1'b0, 12'h064, 12'h34d, 12'h166, 1'b0);
		wr(8'h35, 16'hf014, 3'b000);
		wr(8'h35, 16'hf020, 3'b011);
		wr(8'h35, 16'hf010, 3'b011);
		rd(8'h35, 16'hf014);
		wr(8'h36, 16'hf013, 3'b000);
		wr(8'h35, 16'hf012, 3'b011);
		wr(8'h36, 16'hf015, 3'b011);
		rd(8'h36, 16'hf013);
		wr(8'h35, 16'he829, 3'b000);
		rd(8'h35, 16'hf015);
		for (int i = 0; i < 3; i++) begin
			@(negedge mclk);
			vin_meas = (i == 0) ? 12'h014 : 12'h015;
			startup_ok = (i != 1);
			repeat (2) @(negedge mclk);
			chk("conv_start", {16'h0, i == 2}, {16'h0, conv_start_r});
		end
		loop_slave = 1'b1;
		xact(1'b0, 8'h29, 16'h0000, 17'h10000, 3'b101);
		xact(1'b1, 8'h2b, 16'h0200, 17'h10000, 3'b101);
		rd(8'h35, 16'hf015);
		loop_slave = 1'b0;
		rd(8'h2b, 16'h02cc);
		xact(1'b0, 8'h40, 16'h0000, 17'h10000, 3'b101);
		nv(1'b1);
		wr(8'h29, 16'hf004, 3'b000);
		wr(8'h35, 16'hf01f, 3'b000);
		nv(1'b0);
		rd(8'h29, 16'hf002);
		rd(8'h35, 16'hf015);
		for (int i = 0; i < 8; i++) begin
			v = 12'h166 + 12'($unsigned($random(seed)) % 32'h49b);
			wr(8'h2b, {4'h0, v}, 3'b000);
			rd(8'h2b, {4'h0, v});
		end
		// reset in mid-run: defaults return, restore is refused until a new store
		@(negedge mclk);
		srst = 1'b1;
		repeat (3) @(negedge mclk);
		srst = 1'b0;
		chk("vref_rst2", 17'h000b3, {5'h00, vref_r});
		@(negedge mclk);
		restore_all = 1'b1;
		@(negedge mclk);
		restore_all = 1'b0;
		chk("nv_refused", 17'h00001, {16'h0, cmd_ready_r});
		rd(8'h29, 16'hf004);
		rd(8'h35, 16'hf012);
		chk("pending", 17'h00000, 17'(exp_q.size()));
		tally_and_finish();
	end
endmodule : tb_top
`default_nettype wire
